// ==== design/acs_defs.svh ====
// Constants of the calibration and mode sequencer
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define ACS_MODE_CONV 3'h0
`define ACS_MODE_SELF 3'h1
`define ACS_MODE_SYS_OFFS 3'h2
`define ACS_MODE_SYS_PFS 3'h3
`define ACS_MODE_SYS_NFS 3'h4
`define ACS_MODE_OFFS_IGAIN 3'h5
`define ACS_MODE_SYS_GAIN 3'h6
`define ACS_MODE_RESERVED 3'h7

// ----------------------------------------------------------------
// Calibration register selects and reset values
// ----------------------------------------------------------------
`define ACS_SEL_OFFSET 2'h0
`define ACS_SEL_POS_FS 2'h1
`define ACS_SEL_NEG_FS 2'h2
`define ACS_OFFSET_RST 24'h000000
`define ACS_FS_RST 24'h800000

// ----------------------------------------------------------------
// Timing in conversion periods, the period divider and the gain shift
// ----------------------------------------------------------------
`define ACS_PERIOD_PRESCALE 512
`define ACS_STEP_INT 3'h3
`define ACS_STEP_SYS 3'h4
`define ACS_STEP_GAIN_FIN 3'h1
`define ACS_GAIN_SHIFT 23

`endif

// ==== design/acs_pkg.sv ====
// Types shared by the calibration and mode sequencer
package acs_pkg;

	// Analog front-end steering, one bit per switch
	typedef struct packed {
		logic input_connect;
		logic input_short;
		logic ref_apply;
		logic polarity_rev;
	} acs_analog_ctl_t;

	// Host write into one calibration register
	typedef struct packed {
		logic en;
		logic [1:0] sel;
		logic [23:0] data;
	} acs_cal_wr_t;

	// The three calibration coefficients
	typedef struct packed {
		logic [23:0] offset;
		logic [23:0] pos_fs;
		logic [23:0] neg_fs;
	} acs_cal_regs_t;

endpackage : acs_pkg

// ==== design/acs_sequencer.sv ====
// Mode decode, calibration sequencing and result correction
//
// Operation
// - decode seven modes, code seven reserved
// - neutral coefficients give uncorrected data
// - data-ready low once calibration finishes
// - conversion: ready after three periods
// - conversion corrects, never writes coefficients
// - self: short inputs, store offset
// - self: reference both polarities, store gains
// - self: ready three periods after negative
// - system offset: store, ready after four
// - system positive: store, ready after four
// - system negative: store, ready after four
// - offset/internal gain: external offset first
// - then reference gains, ready three later
// - system gain: negative, reversed positive, one
// - period is prescale times filter code
// - three 24-bit host-accessible coefficient registers
`timescale 1ns/100ps
`include "acs_defs.svh"

module acs_sequencer #(
	parameter int PRESCALE = `ACS_PERIOD_PRESCALE
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [2:0] i_operating_mode_field,
	input wire logic [10:0] i_notch_code,
	input wire logic [23:0] i_raw_result,
	input wire acs_pkg::acs_cal_wr_t i_cal_wr,
	output acs_pkg::acs_cal_regs_t o_cal,
	output acs_pkg::acs_analog_ctl_t o_analog_ctl,
	output logic [23:0] o_data_out,
	output logic o_result_valid_n,
	output logic o_period_tick,
	output logic o_cal_busy
);

	typedef enum logic [2:0] {
		ST_WAIT,
		ST_OFFS,
		ST_PFS,
		ST_NFS,
		ST_FIN,
		ST_RUN
	} acs_state_t;

	// ----------------------------------------------------------------
	// Conversion period divider
	// ----------------------------------------------------------------
	logic [31:0] div_q;
	logic [31:0] div_d;
	logic [31:0] period_cyc;
	logic tick;

	// A zero code would stall the converter, so it ticks every cycle instead
	assign period_cyc = 32'(PRESCALE) * {21'h0, i_notch_code};
	assign tick = (div_q + 32'h1) >= period_cyc;
	assign div_d = tick ? 32'h0 : div_q + 32'h1;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div_q <= 32'h0;
		end else begin
			div_q <= div_d;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	acs_state_t st_q;
	acs_state_t st_d;
	acs_state_t st_entry;
	acs_state_t st_next;
	logic [2:0] mode_q;
	logic [2:0] pc_q;
	logic [2:0] pc_d;
	logic [2:0] need;
	logic restart;
	logic step_end;
	logic m_int;
	logic m_sgain;
	logic m_single;

	// Reserved code is not trapped; it behaves as conversion
	assign restart = i_operating_mode_field != mode_q;
	assign m_int = (mode_q == `ACS_MODE_SELF) || (mode_q == `ACS_MODE_OFFS_IGAIN);
	assign m_sgain = mode_q == `ACS_MODE_SYS_GAIN;
	assign m_single = (mode_q == `ACS_MODE_SYS_OFFS) || (mode_q == `ACS_MODE_SYS_PFS)
		|| (mode_q == `ACS_MODE_SYS_NFS);

	always_comb begin
		case (i_operating_mode_field)
			`ACS_MODE_SELF: st_entry = ST_OFFS;
			`ACS_MODE_SYS_OFFS: st_entry = ST_OFFS;
			`ACS_MODE_OFFS_IGAIN: st_entry = ST_OFFS;
			`ACS_MODE_SYS_PFS: st_entry = ST_PFS;
			`ACS_MODE_SYS_NFS: st_entry = ST_NFS;
			`ACS_MODE_SYS_GAIN: st_entry = ST_NFS;
			default: st_entry = ST_WAIT;
		endcase
	end

	// ----------------------------------------------------------------
	// Step sequencer
	// ----------------------------------------------------------------
	assign need = (m_single && st_q != ST_WAIT) ? `ACS_STEP_SYS
		: (m_sgain && st_q == ST_FIN) ? `ACS_STEP_GAIN_FIN : `ACS_STEP_INT;
	assign step_end = tick && (pc_q + 3'h1 == need) && st_q != ST_RUN;

	always_comb begin
		case (st_q)
			ST_OFFS: st_next = m_int ? ST_PFS : ST_RUN;
			ST_PFS: st_next = m_int ? ST_NFS : (m_sgain ? ST_FIN : ST_RUN);
			ST_NFS: st_next = m_int ? ST_FIN : (m_sgain ? ST_PFS : ST_RUN);
			ST_FIN: st_next = ST_RUN;
			ST_WAIT: st_next = ST_RUN;
			default: st_next = ST_RUN;
		endcase
	end

	assign st_d = restart ? st_entry : (step_end ? st_next : st_q);
	assign pc_d = (restart || step_end) ? 3'h0 : (tick ? pc_q + 3'h1 : pc_q);

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= ST_WAIT;
			mode_q <= `ACS_MODE_CONV;
			pc_q <= 3'h0;
		end else begin
			st_q <= st_d;
			mode_q <= i_operating_mode_field;
			pc_q <= pc_d;
		end
	end

	// ----------------------------------------------------------------
	// Analog steering
	// ----------------------------------------------------------------
	logic sw_short;
	logic sw_ref;
	logic sw_rev;

	assign sw_short = st_q == ST_OFFS && mode_q == `ACS_MODE_SELF;
	assign sw_ref = m_int && (st_q == ST_PFS || st_q == ST_NFS);
	assign sw_rev = (sw_ref && st_q == ST_NFS) || (m_sgain && st_q == ST_PFS);
	assign o_analog_ctl = '{input_connect: !sw_short && !sw_ref, input_short: sw_short,
		ref_apply: sw_ref, polarity_rev: sw_rev};

	// ----------------------------------------------------------------
	// Calibration registers
	// ----------------------------------------------------------------
	logic [23:0] off_q;
	logic [23:0] off_d;
	logic [23:0] pfs_q;
	logic [23:0] pfs_d;
	logic [23:0] nfs_q;
	logic [23:0] nfs_d;
	logic hw_off;
	logic hw_pfs;
	logic hw_nfs;

	// Stores only happen at the end of calibration steps, never in conversion
	assign hw_off = step_end && st_q == ST_OFFS;
	assign hw_pfs = step_end && st_q == ST_PFS;
	assign hw_nfs = step_end && st_q == ST_NFS;

	// A hardware store beats a host write landing in the same cycle
	assign off_d = hw_off ? i_raw_result
		: (i_cal_wr.en && i_cal_wr.sel == `ACS_SEL_OFFSET) ? i_cal_wr.data : off_q;
	assign pfs_d = hw_pfs ? i_raw_result
		: (i_cal_wr.en && i_cal_wr.sel == `ACS_SEL_POS_FS) ? i_cal_wr.data : pfs_q;
	assign nfs_d = hw_nfs ? i_raw_result
		: (i_cal_wr.en && i_cal_wr.sel == `ACS_SEL_NEG_FS) ? i_cal_wr.data : nfs_q;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			off_q <= `ACS_OFFSET_RST;
			pfs_q <= `ACS_FS_RST;
			nfs_q <= `ACS_FS_RST;
		end else begin
			off_q <= off_d;
			pfs_q <= pfs_d;
			nfs_q <= nfs_d;
		end
	end

	assign o_cal = '{offset: off_q, pos_fs: pfs_q, neg_fs: nfs_q};

	// ----------------------------------------------------------------
	// Result correction
	// ----------------------------------------------------------------
	logic signed [24:0] diff;
	logic [23:0] gain;
	logic signed [49:0] prod;
	logic signed [49:0] scl;
	logic [23:0] corr;

	// Slope 800000h is unity, so neutral coefficients pass the raw value
	assign diff = $signed({i_raw_result[23], i_raw_result}) - $signed({off_q[23], off_q});
	assign gain = diff[24] ? nfs_q : pfs_q;
	assign prod = 50'(diff * $signed({1'b0, gain}));
	assign scl = prod >>> `ACS_GAIN_SHIFT;
	assign corr = (scl > 50'sh7FFFFF) ? 24'h7FFFFF
		: (scl < -50'sh800000) ? 24'h800000 : scl[23:0];

	// ----------------------------------------------------------------
	// Output register and data-ready
	// ----------------------------------------------------------------
	logic [23:0] dout_q;
	logic [23:0] dout_d;
	logic rdy_n_q;
	logic rdy_n_d;
	logic load;

	assign load = !restart && ((step_end && st_next == ST_RUN) || (tick && st_q == ST_RUN));
	assign dout_d = load ? corr : dout_q;
	assign rdy_n_d = restart ? 1'b1 : ((step_end && st_next == ST_RUN) ? 1'b0 : rdy_n_q);

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dout_q <= 24'h000000;
			rdy_n_q <= 1'b1;
		end else begin
			dout_q <= dout_d;
			rdy_n_q <= rdy_n_d;
		end
	end

	assign o_data_out = dout_q;
	assign o_result_valid_n = rdy_n_q;
	assign o_period_tick = tick;
	assign o_cal_busy = st_q != ST_RUN && st_q != ST_WAIT;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	// Last counted period of a three-period step
	sequence s_last_tick;
		tick && !restart && pc_q == 3'h2;
	endsequence

	// A finished step that no mode change cut short
	sequence s_step_kept;
		step_end && !restart;
	endsequence

	rdy_means_run_a: assert property (!o_result_valid_n == (st_q == ST_RUN))
		else $error("data-ready out of step with finished state");
	conv_wait_three_a: assert property ((st_q == ST_WAIT) and s_last_tick
		|=> st_q == ST_RUN && !o_result_valid_n)
		else $error("conversion not ready after three periods");
	restart_drops_rdy_a: assert property (restart |=> o_result_valid_n)
		else $error("data-ready kept across a mode change");
	conv_keeps_cal_a: assert property ((st_q == ST_WAIT || st_q == ST_RUN)
		&& !i_cal_wr.en |=> $stable(o_cal))
		else $error("coefficients changed during conversion");
	self_short_a: assert property (st_q == ST_OFFS && mode_q == `ACS_MODE_SELF
		|-> o_analog_ctl.input_short && !o_analog_ctl.input_connect)
		else $error("self offset step without shorted inputs");
	self_offset_store_a: assert property ((st_q == ST_OFFS && m_int) and s_last_tick
		|=> o_cal.offset == $past(i_raw_result) && st_q == ST_PFS)
		else $error("offset not stored after three periods");
	self_pos_store_a: assert property ((m_int && st_q == ST_PFS) and s_step_kept
		|=> o_cal.pos_fs == $past(i_raw_result) && st_q == ST_NFS)
		else $error("positive full scale not stored before reversal");
	ref_polarity_a: assert property (m_int && st_q == ST_NFS
		|-> o_analog_ctl.ref_apply && o_analog_ctl.polarity_rev)
		else $error("negative step without reversed reference");
	self_fin_three_a: assert property ((m_int && st_q == ST_FIN) and s_last_tick
		|=> !o_result_valid_n)
		else $error("internal gain calibration not ready after final wait");
	single_four_a: assert property (m_single && st_q != ST_WAIT && st_q != ST_RUN
		&& tick && !restart && pc_q == 3'h3 |=> !o_result_valid_n)
		else $error("single-step calibration not ready after four");
	neg_store_a: assert property (hw_nfs && !restart |=> o_cal.neg_fs == $past(i_raw_result))
		else $error("negative full scale not stored");
	igain_ext_offset_a: assert property (st_q == ST_OFFS && mode_q == `ACS_MODE_OFFS_IGAIN
		|-> o_analog_ctl.input_connect && !o_analog_ctl.input_short && !o_analog_ctl.ref_apply)
		else $error("external offset step not taken from the inputs");
	gain_neg_first_a: assert property ((m_sgain && st_q == ST_NFS) and s_step_kept
		|=> o_cal.neg_fs == $past(i_raw_result) && st_q == ST_PFS)
		else $error("gain calibration did not store negative first");
	gain_fin_one_a: assert property (m_sgain && st_q == ST_FIN && tick && !restart
		|=> !o_result_valid_n)
		else $error("gain calibration not ready one period after positive");
	gain_order_a: assert property (m_sgain && st_q == ST_PFS
		|-> o_analog_ctl.polarity_rev && o_analog_ctl.input_connect && !o_analog_ctl.ref_apply)
		else $error("gain positive step without internal reversal");
	host_write_a: assert property (i_cal_wr.en && i_cal_wr.sel == `ACS_SEL_POS_FS && !hw_pfs
		|=> o_cal.pos_fs == $past(i_cal_wr.data))
		else $error("host write to positive full scale lost");
	period_len_a: assert property (tick && $stable(i_notch_code)
		&& 32'(PRESCALE) * {21'h0, i_notch_code} == 32'h4 |=> !tick [*3] ##1 tick)
		else $error("conversion period of four cycles not kept");

endmodule : acs_sequencer

// ==== test/acs_afe_model.sv ====
// Front-end model that answers the sequencer's switch settings with a raw result
`timescale 1ns/100ps
module acs_afe_model #(
	parameter logic [23:0] SHORT_VAL = 24'h000012,
	parameter logic [23:0] REF_VAL = 24'h3FFF00
) (
	input wire acs_pkg::acs_analog_ctl_t i_ctl,
	input wire logic [23:0] i_ext,
	output logic [23:0] o_raw
);
	// Shorted inputs win over the reference so a stuck short shows as wrong full-scale gains
	assign o_raw = i_ctl.input_short ? SHORT_VAL :
		i_ctl.ref_apply ? (i_ctl.polarity_rev ? -REF_VAL : REF_VAL) :
		i_ctl.polarity_rev ? -i_ext : i_ext;
endmodule : acs_afe_model

// ==== test/adc_calibration_mode_sequencer_tb_top.sv ====
// Self-checking bench of the calibration and mode sequencer
`timescale 1ns/100ps
module adc_calibration_mode_sequencer_tb_top;
	localparam logic [23:0] SHORT_VAL = 24'h000012;
	localparam logic [23:0] REF_VAL = 24'h3FFF00;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [10:0] notch = 11'h004;
	logic [23:0] ext = 24'h000000;
	logic [23:0] raw, data_out;
	logic valid_n, tick, busy;
	acs_pkg::acs_cal_wr_t cal_wr = '0;
	acs_pkg::acs_cal_regs_t cal, exp_cal;
	acs_pkg::acs_analog_ctl_t actl;
	logic [31:0] seed = 32'h00002F65;
	logic [2:0] order [8] = '{3'h2, 3'h3, 3'h4, 3'h1, 3'h5, 3'h6, 3'h2, 3'h0};
	int n_errors = 0;
	int cmp_count = 0;
	int cyc;
	always #2 clk = ~clk;
	acs_afe_model #(.SHORT_VAL(SHORT_VAL), .REF_VAL(REF_VAL)) afe (.i_ctl(actl), .i_ext(ext),
		.o_raw(raw));
	acs_sequencer #(.PRESCALE(1)) dut (.i_core_clk(clk), .i_rst_b(rst_b),
		.i_operating_mode_field(mode), .i_notch_code(notch), .i_raw_result(raw),
		.i_cal_wr(cal_wr), .o_cal(cal), .o_analog_ctl(actl), .o_data_out(data_out),
		.o_result_valid_n(valid_n), .o_period_tick(tick), .o_cal_busy(busy));
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next
	function automatic int ticks_for(input logic [2:0] m);
		case (m)
			3'h1, 3'h5: return 12;
			3'h2, 3'h3, 3'h4: return 4;
			3'h6: return 7;
			default: return 3;
		endcase
	endfunction : ticks_for
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic check_cal();
		check(cal.offset, exp_cal.offset);
		check(cal.pos_fs, exp_cal.pos_fs);
		check(cal.neg_fs, exp_cal.neg_fs);
	endtask : check_cal
	task automatic wait_tick();
		int lim;
		lim = 0;
		do begin
			@(negedge clk);
			lim++;
		end while (tick !== 1'b1 && lim < 100);
	endtask : wait_tick
	task automatic run_mode(input logic [2:0] m);
		logic [23:0] e;
		seed = lfsr_next(seed);
		e = seed[23:0];
		@(posedge clk);
		ext <= e;
		repeat (2) @(posedge clk);
		mode <= m;
		@(posedge clk);
		for (int i = 0; i < ticks_for(m); i++) wait_tick();
		check({23'h0, valid_n}, 24'h000001);
		check({23'h0, busy}, {23'h0, m != 3'h0 && m != 3'h7});
		@(posedge clk);
		#1;
		check({23'h0, valid_n}, 24'h000000);
		check({23'h0, busy}, 24'h000000);
		case (m)
			3'h1: exp_cal = '{SHORT_VAL, REF_VAL, -REF_VAL};
			3'h2: exp_cal.offset = e;
			3'h3: exp_cal.pos_fs = e;
			3'h4: exp_cal.neg_fs = e;
			3'h5: exp_cal = '{e, REF_VAL, -REF_VAL};
			3'h6: exp_cal = '{exp_cal.offset, -e, e};
			default: ;
		endcase
		check_cal();
	endtask : run_mode
	task automatic wr(input logic [1:0] s, input logic [23:0] d);
		@(posedge clk);
		cal_wr <= '{1'b1, s, d};
		@(posedge clk);
		cal_wr <= '0;
		case (s)
			2'h0: exp_cal.offset = d;
			2'h1: exp_cal.pos_fs = d;
			2'h2: exp_cal.neg_fs = d;
			default: ;
		endcase
		#1;
		check_cal();
	endtask : wr
	task automatic end_of_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// ----------------------------------------------------------------
	// Watchdog, sized well above the few hundred cycles the run needs
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		exp_cal = '{24'h000000, 24'h800000, 24'h800000};
		check_cal();
		check({23'h0, valid_n}, 24'h000001);
		foreach (order[i]) run_mode(order[i]);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr_next(seed);
			wr(seed[25:24], seed[23:0]);
		end
		wr(2'h3, 24'h5A5A5A);
		wr(2'h0, 24'h000000);
		wr(2'h1, 24'h800000);
		wr(2'h2, 24'h800000);
		wait_tick();
		@(posedge clk);
		#1;
		check(data_out, ext);
		check_cal();
		wait_tick();
		cyc = 0;
		do begin
			@(negedge clk);
			cyc++;
		end while (tick !== 1'b1 && cyc < 100);
		check(24'(cyc), 24'h000004);
		// Change the code where the old period ends, then recalibrate
		repeat (4) @(posedge clk);
		notch <= 11'h002;
		run_mode(3'h2);
		wait_tick();
		cyc = 0;
		do begin
			@(negedge clk);
			cyc++;
		end while (tick !== 1'b1 && cyc < 100);
		check(24'(cyc), 24'h000002);
		end_of_test();
	end
endmodule : adc_calibration_mode_sequencer_tb_top
